// ---- inc/mas_pkg.sv ----
/*
  Shared constants and types for the memory, addressing and return stack block
  of the 8-bit core: data space offsets, vectors, widths, reset values and the
  command and ALU function encodings used by the instruction sequencer.
  Assumes a single clock and a synchronous reset in the enclosing core.
*/
package mas_pkg;

  // Widths
  localparam int unsigned PC_W       = 11;
  localparam int unsigned PW_W       = 14;
  localparam int unsigned DA_W       = 7;
  localparam int unsigned PM_WORDS   = 2048;
  localparam int unsigned GP_BYTES   = 96;
  localparam int unsigned STK_LEVELS = 4;

  // Program memory vectors
  localparam logic [10:0] VEC_RESET = 11'h000;
  localparam logic [10:0] VEC_USB   = 11'h004;
  localparam logic [10:0] VEC_TMR   = 11'h00c;

  // Table page fields
  localparam logic [2:0] TBL_LAST_PAGE = 3'h7;
  localparam int unsigned TBL_PAGE_LSB = 8;

  // Data space offsets
  localparam logic [6:0] ADR_IND0    = 7'h00;
  localparam logic [6:0] ADR_MPTR0   = 7'h01;
  localparam logic [6:0] ADR_IND1    = 7'h02;
  localparam logic [6:0] ADR_MPTR1   = 7'h03;
  localparam logic [6:0] ADR_BANK    = 7'h04;
  localparam logic [6:0] ADR_ACCUM   = 7'h05;
  localparam logic [6:0] ADR_PC_LOW  = 7'h06;
  localparam logic [6:0] ADR_TPTR_LO = 7'h07;
  localparam logic [6:0] ADR_TBL_HI  = 7'h08;
  localparam logic [6:0] ADR_STATUS  = 7'h0a;
  localparam logic [6:0] ADR_TPTR_HI = 7'h1f;
  localparam logic [6:0] ADR_GP_BASE = 7'h20;

  // Special addresses served outside this block, one bit per address 00H-1FH
  localparam logic [31:0] EXT_SFR_MASK = 32'h1c3f_8a00;

  // Status flag positions
  localparam int unsigned FLG_C  = 0;
  localparam int unsigned FLG_AC = 1;
  localparam int unsigned FLG_Z  = 2;
  localparam int unsigned FLG_OV = 3;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_BANK = 8'h00;

  // Decimal adjust thresholds
  localparam logic [3:0] DAA_LIMIT = 4'h9;
  localparam logic [7:0] DAA_LO    = 8'h06;
  localparam logic [7:0] DAA_HI    = 8'h60;

  typedef enum logic [3:0] {
    OP_NOP, OP_ALU, OP_SKZ, OP_SKNZ, OP_SETB, OP_CLRB, OP_TBL_CUR,
    OP_TBL_LAST, OP_JMP, OP_CALL, OP_SUB_RET, OP_INT_RET
  } mas_op_t;

  typedef enum logic [3:0] {
    FN_ADD, FN_ADC, FN_SUB, FN_SBC, FN_DAA, FN_AND, FN_OR, FN_XOR,
    FN_CPL, FN_RL, FN_RR, FN_RLC, FN_RRC, FN_INC, FN_DEC, FN_MOVE
  } mas_fn_t;

  typedef enum logic [1:0] {
    DST_NONE, DST_ACCUM, DST_MEM, DST_PASS
  } mas_dst_t;

endpackage : mas_pkg

// ---- hw/mas_mem_addr_stack.sv ----
/*
  Program memory, table reads, return stack, bank 0 data memory (bank 1 goes to the outside port) with
  indirect pointers, accumulator and ALU of the 8-bit core.
  Assumes the sequencer offers one command at a time and holds it until
  CMD_READY_O, that interrupt requests arrive already enabled and stay
  pending until acknowledged, and that other special registers live outside.
*/
`timescale 1ns/100ps

module mas_mem_addr_stack #(
  parameter bit TABLE_POINTER_HIGH_OPTION = 1'b0
) (
  input  wire logic               CLK_I,
  input  wire logic               SYS_RST_I,
  input  wire logic               PM_WE_I,
  input  wire logic [10:0]        PM_WADDR_I,
  input  wire logic [13:0]        PM_WDATA_I,
  output logic      [10:0]        FETCH_ADDR_O,
  output logic      [13:0]        FETCH_WORD_O,
  input  wire logic               CMD_VALID_I,
  output logic                    CMD_READY_O,
  input  wire mas_pkg::mas_op_t   CMD_OP_I,
  input  wire mas_pkg::mas_fn_t   CMD_FN_I,
  input  wire mas_pkg::mas_dst_t  CMD_DST_I,
  input  wire logic [6:0]         CMD_ADDR_I,
  input  wire logic [7:0]         CMD_IMM_I,
  input  wire logic               CMD_USE_IMM_I,
  input  wire logic [2:0]         CMD_BIT_I,
  input  wire logic [10:0]        CMD_TARGET_I,
  input  wire logic               USB_REQ_I,
  input  wire logic               TMR_REQ_I,
  output logic                    INT_ACK_USB_O,
  output logic                    INT_ACK_TMR_O,
  output logic                    INT_RETURN_O,
  output logic                    EXT_SEL_O,
  output logic                    EXT_WE_O,
  output logic      [6:0]         EXT_ADDR_O,
  output logic                    EXT_BANK_O,
  output logic      [7:0]         EXT_WDATA_O,
  input  wire logic [7:0]         EXT_RDATA_I,
  output logic      [7:0]         ACCUM_O,
  output logic      [3:0]         FLAGS_O,
  output logic                    STACK_FULL_O
);
  import mas_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Types

  typedef enum logic { ST_RUN, ST_SECOND } mas_phase_t;

  typedef struct packed {
    logic [6:0] addr;
    logic       bank;
    logic       nul;
  } mas_loc_t;

  typedef struct packed {
    logic [7:0] res;
    logic [3:0] flg;
    logic [3:0] upd;
  } mas_alu_t;

  typedef struct packed {
    mas_phase_t                    ph;
    logic                          tbl;
    logic [10:0]                   tad;
    mas_loc_t                      tloc;
    logic [10:0]                   pc;
    logic [STK_LEVELS-1:0][10:0]   stk;
    logic [1:0]                    sidx;
    logic [2:0]                    cnt;
    logic [6:0]                    mptr0;
    logic [6:0]                    mptr1;
    logic [7:0]                    bank;
    logic [7:0]                    accum;
    logic [7:0]                    tptr_lo;
    logic [7:0]                    tptr_hi;
    logic [7:0]                    tbl_hi;
    logic [3:0]                    flg;
    logic [GP_BYTES-1:0][7:0]      ram;
    logic [PM_WORDS-1:0][13:0]     pm;
  } mas_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Direct addresses always hit bank 0; only the second pointer sees bank 1
  function automatic mas_loc_t resolve(input logic [6:0] a, input logic [6:0] p0,
                                       input logic [6:0] p1, input logic b);
    mas_loc_t l;
    l = '0;
    if (a == ADR_IND0) begin
      l.addr = p0;
      l.bank = 1'b0;
      l.nul  = (p0 == ADR_IND0) || (p0 == ADR_IND1);
    end else if (a == ADR_IND1) begin
      l.addr = p1;
      l.bank = b;
      l.nul  = (p1 == ADR_IND0) || (p1 == ADR_IND1);
    end else begin
      l.addr = a;
      l.bank = 1'b0;
      l.nul  = 1'b0;
    end
    return l;
  endfunction : resolve

  // Bank 1 above 20H and foreign special registers go to the outside port
  function automatic logic is_ext(input mas_loc_t l);
    if (l.nul) begin
      return 1'b0;
    end else if (l.addr >= ADR_GP_BASE) begin
      return l.bank;
    end else begin
      return EXT_SFR_MASK[l.addr[4:0]];
    end
  endfunction : is_ext

  // Arithmetic, logic, rotate and count unit with flag updates
  function automatic mas_alu_t alu(input mas_fn_t fn, input logic [7:0] a,
                                   input logic [7:0] b, input logic [3:0] f);
    mas_alu_t   r;
    logic [7:0] bb;
    logic       cin;
    logic [8:0] s;
    logic [4:0] h;
    r   = '0;
    bb  = b;
    cin = 1'b0;
    s   = '0;
    h   = '0;
    case (fn)
      FN_ADD, FN_ADC, FN_SUB, FN_SBC: begin
        bb  = (fn == FN_SUB || fn == FN_SBC) ? ~b : b;
        cin = (fn == FN_ADD) ? 1'b0 : ((fn == FN_SUB) ? 1'b1 : f[FLG_C]);
        s   = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
        h   = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
        r.res        = s[7:0];
        r.flg[FLG_C] = s[8];
        r.flg[FLG_AC] = h[4];
        r.flg[FLG_OV] = (a[7] == bb[7]) && (s[7] != a[7]);
        r.upd        = 4'hf;
      end
      FN_DAA: begin
        s = {1'b0, a};
        if (a[3:0] > DAA_LIMIT || f[FLG_AC]) begin
          s = s + {1'b0, DAA_LO};
        end
        if (s[7:4] > DAA_LIMIT || s[8] || f[FLG_C]) begin
          s = s + {1'b0, DAA_HI};
        end
        r.res        = s[7:0];
        r.flg[FLG_C] = s[8] | f[FLG_C];
        r.upd[FLG_C] = 1'b1;
      end
      FN_AND:  r.res = a & b;
      FN_OR:   r.res = a | b;
      FN_XOR:  r.res = a ^ b;
      FN_CPL:  r.res = ~b;
      FN_RL:   r.res = {b[6:0], b[7]};
      FN_RR:   r.res = {b[0], b[7:1]};
      FN_RLC: begin
        r.res        = {b[6:0], f[FLG_C]};
        r.flg[FLG_C] = b[7];
        r.upd[FLG_C] = 1'b1;
      end
      FN_RRC: begin
        r.res        = {f[FLG_C], b[7:1]};
        r.flg[FLG_C] = b[0];
        r.upd[FLG_C] = 1'b1;
      end
      FN_INC:  r.res = b + 8'h01;
      FN_DEC:  r.res = b - 8'h01;
      default: r.res = b;
    endcase
    // Zero flag for every arithmetic and logic result except decimal adjust, not moves or rotates
    r.flg[FLG_Z] = (r.res == 8'h00);
    r.upd[FLG_Z] = !(fn inside {FN_MOVE, FN_RL, FN_RR, FN_RLC, FN_RRC, FN_DAA});
    return r;
  endfunction : alu

  ////////////////////////////////////////////////////////////////////////////
  // Datapath signals

  mas_state_t  s_q;
  mas_state_t  s_d;
  mas_loc_t    cloc;
  mas_loc_t    wloc;
  mas_alu_t    ar;
  logic [7:0]  rd;
  logic [7:0]  opnd;
  logic [7:0]  wd;
  logic        we;
  logic        take_int;
  logic        accept;
  logic        full;
  logic [10:0] pc_inc;
  logic [6:0]  gidx;

  // Deferral: a full stack holds the request off without losing it
  assign full     = (s_q.cnt == 3'(STK_LEVELS));
  assign take_int = (s_q.ph == ST_RUN) && (USB_REQ_I || TMR_REQ_I) && !full;
  assign accept   = (s_q.ph == ST_RUN) && !take_int && CMD_VALID_I;
  assign cloc     = resolve(CMD_ADDR_I, s_q.mptr0, s_q.mptr1, s_q.bank[0]);
  assign pc_inc   = s_q.pc + 11'h001;

  // Operand read mux; reads never disturb state
  always_comb begin
    gidx = cloc.addr - ADR_GP_BASE;
    rd   = RST_BYTE;
    if (cloc.nul) begin
      rd = RST_BYTE;
    end else if (is_ext(cloc)) begin
      rd = EXT_RDATA_I;
    end else if (cloc.addr >= ADR_GP_BASE) begin
      rd = s_q.ram[gidx];
    end else if (cloc.addr == ADR_MPTR0) begin
      rd = {1'b0, s_q.mptr0};
    end else if (cloc.addr == ADR_MPTR1) begin
      rd = {1'b0, s_q.mptr1};
    end else if (cloc.addr == ADR_BANK) begin
      rd = s_q.bank;
    end else if (cloc.addr == ADR_ACCUM) begin
      rd = s_q.accum;
    end else if (cloc.addr == ADR_PC_LOW) begin
      rd = s_q.pc[7:0];
    end else if (cloc.addr == ADR_TPTR_LO) begin
      rd = s_q.tptr_lo;
    end else if (cloc.addr == ADR_TBL_HI) begin
      rd = s_q.tbl_hi;
    end else if (cloc.addr == ADR_STATUS) begin
      rd = {4'h0, s_q.flg};
    end else if (cloc.addr == ADR_TPTR_HI) begin
      rd = s_q.tptr_hi;
    end else begin
      rd = RST_BYTE;
    end
  end

  assign opnd = CMD_USE_IMM_I ? CMD_IMM_I : rd;
  assign ar   = alu(CMD_FN_I, s_q.accum, opnd, s_q.flg);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d  = s_q;
    we   = 1'b0;
    wd   = RST_BYTE;
    wloc = cloc;
    INT_ACK_USB_O = 1'b0;
    INT_ACK_TMR_O = 1'b0;
    INT_RETURN_O  = 1'b0;
    if (s_q.ph == ST_SECOND) begin
      // Second cycle: dummy for transfers, data move for table reads
      s_d.ph  = ST_RUN;
      s_d.tbl = 1'b0;
      if (s_q.tbl) begin
        wloc       = s_q.tloc;
        wd         = s_q.pm[s_q.tad][7:0];
        we         = 1'b1;
        s_d.tbl_hi = {2'b00, s_q.pm[s_q.tad][13:8]};
      end
    end else if (take_int) begin
      // Push the next instruction address, lower vector wins
      s_d.stk[s_q.sidx] = s_q.pc;
      s_d.sidx = s_q.sidx + 2'd1;
      s_d.cnt  = s_q.cnt + 3'd1;
      s_d.ph   = ST_SECOND;
      if (USB_REQ_I) begin
        s_d.pc        = VEC_USB;
        INT_ACK_USB_O = 1'b1;
      end else begin
        s_d.pc        = VEC_TMR;
        INT_ACK_TMR_O = 1'b1;
      end
    end else if (accept) begin
      s_d.pc = pc_inc;
      case (CMD_OP_I)
        OP_ALU, OP_SKZ, OP_SKNZ: begin
          for (int i = 0; i < 4; i++) begin
            if (ar.upd[i]) begin
              s_d.flg[i] = ar.flg[i];
            end
          end
          if (CMD_DST_I == DST_ACCUM) begin
            s_d.accum = ar.res;
          end else if (CMD_DST_I == DST_MEM) begin
            we = 1'b1;
            wd = ar.res;
          end else if (CMD_DST_I == DST_PASS) begin
            we = 1'b1;
            wd = s_q.accum;
          end
          if ((CMD_OP_I == OP_SKZ && ar.res == 8'h00) ||
              (CMD_OP_I == OP_SKNZ && ar.res != 8'h00)) begin
            s_d.pc = s_q.pc + 11'h002;
            s_d.ph = ST_SECOND;
          end
        end
        OP_SETB, OP_CLRB: begin
          we = 1'b1;
          wd = rd;
          wd[CMD_BIT_I] = (CMD_OP_I == OP_SETB);
        end
        OP_TBL_CUR, OP_TBL_LAST: begin
          s_d.tbl  = 1'b1;
          s_d.tloc = cloc;
          s_d.ph   = ST_SECOND;
          if (CMD_OP_I == OP_TBL_LAST) begin
            s_d.tad = {TBL_LAST_PAGE, s_q.tptr_lo};
          end else if (TABLE_POINTER_HIGH_OPTION) begin
            s_d.tad = {s_q.tptr_hi[2:0], s_q.tptr_lo};
          end else begin
            s_d.tad = {s_q.pc[PC_W-1:TBL_PAGE_LSB], s_q.tptr_lo};
          end
        end
        OP_JMP: begin
          s_d.pc = CMD_TARGET_I;
          s_d.ph = ST_SECOND;
        end
        OP_CALL: begin
          // Ring overwrite keeps the newest four addresses
          s_d.stk[s_q.sidx] = pc_inc;
          s_d.sidx = s_q.sidx + 2'd1;
          s_d.cnt  = full ? s_q.cnt : s_q.cnt + 3'd1;
          s_d.pc   = CMD_TARGET_I;
          s_d.ph   = ST_SECOND;
        end
        OP_SUB_RET, OP_INT_RET: begin
          s_d.sidx = s_q.sidx - 2'd1;
          s_d.pc   = s_q.stk[s_q.sidx - 2'd1];
          s_d.cnt  = (s_q.cnt == 3'd0) ? 3'd0 : s_q.cnt - 3'd1;
          s_d.ph   = ST_SECOND;
          INT_RETURN_O = (CMD_OP_I == OP_INT_RET);
        end
        default: begin
        end
      endcase
    end

    // Single write port into the data space
    if (we && !wloc.nul && !is_ext(wloc)) begin
      if (wloc.addr >= ADR_GP_BASE) begin
        s_d.ram[7'(wloc.addr - ADR_GP_BASE)] = wd;
      end else if (wloc.addr == ADR_MPTR0) begin
        s_d.mptr0 = wd[6:0];
      end else if (wloc.addr == ADR_MPTR1) begin
        s_d.mptr1 = wd[6:0];
      end else if (wloc.addr == ADR_BANK) begin
        s_d.bank = wd;
      end else if (wloc.addr == ADR_ACCUM) begin
        s_d.accum = wd;
      end else if (wloc.addr == ADR_PC_LOW) begin
        s_d.pc = {s_q.pc[PC_W-1:TBL_PAGE_LSB], wd};
        s_d.ph = ST_SECOND;
      end else if (wloc.addr == ADR_TPTR_LO) begin
        s_d.tptr_lo = wd;
      end else if (wloc.addr == ADR_TPTR_HI) begin
        s_d.tptr_hi = wd;
      end else if (wloc.addr == ADR_STATUS) begin
        s_d.flg = wd[3:0];
      end
    end

    // Reset clears control state but keeps the loaded program
    if (SYS_RST_I) begin
      s_d      = '0;
      s_d.pm   = s_q.pm;
      s_d.ph   = ST_RUN;
      s_d.pc   = VEC_RESET;
      s_d.bank = RST_BANK;
    end

    // Loader port stays live during reset so code can be preloaded
    if (PM_WE_I) begin
      s_d.pm[PM_WADDR_I] = PM_WDATA_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge CLK_I) begin
    s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Outside port follows the table destination in its second cycle
  assign EXT_SEL_O    = (accept || (s_q.ph == ST_SECOND && s_q.tbl)) && is_ext(wloc);
  assign EXT_WE_O     = EXT_SEL_O && we;
  assign EXT_ADDR_O   = wloc.addr;
  assign EXT_BANK_O   = wloc.bank;
  assign EXT_WDATA_O  = wd;
  assign CMD_READY_O  = (s_q.ph == ST_RUN) && !take_int;
  assign FETCH_ADDR_O = s_q.pc;
  assign FETCH_WORD_O = s_q.pm[s_q.pc];
  assign ACCUM_O      = s_q.accum;
  assign FLAGS_O      = s_q.flg;
  assign STACK_FULL_O = full;

endmodule : mas_mem_addr_stack

// ---- test/mas_mem_addr_stack_chk.sv ----
/*
  Port-level assertions for the memory, addressing and return stack block.
  Assumes one clock and a synchronous active-high reset; bound at the foot.
*/
`timescale 1ns/100ps
module mas_mem_addr_stack_chk
  import mas_pkg::*;
(
  input wire logic              CLK_I,
  input wire logic              SYS_RST_I,
  input wire logic              CMD_VALID_I,
  input wire logic              CMD_READY_O,
  input wire mas_pkg::mas_op_t  CMD_OP_I,
  input wire logic [6:0]        CMD_ADDR_I,
  input wire logic [10:0]       CMD_TARGET_I,
  input wire logic              USB_REQ_I,
  input wire logic              TMR_REQ_I,
  input wire logic              INT_ACK_USB_O,
  input wire logic              INT_ACK_TMR_O,
  input wire logic              INT_RETURN_O,
  input wire logic              EXT_SEL_O,
  input wire logic              EXT_BANK_O,
  input wire logic [10:0]       FETCH_ADDR_O,
  input wire logic              STACK_FULL_O
);
  ////////////////////////////////////////////////////////////
  // One domain, so clock and reset are given once
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  // Return accepted this cycle, frees one stack level
  wire logic ret_take = CMD_VALID_I && CMD_READY_O
                        && (CMD_OP_I == OP_SUB_RET || CMD_OP_I == OP_INT_RET);

  sequence s_taken(mas_op_t op);
    CMD_VALID_I && CMD_READY_O && CMD_OP_I == op;
  endsequence

  // Ack cycle and dummy cycle stall; a waiting request may stall longer
  sequence s_int_stall;
    !CMD_READY_O ##1 !CMD_READY_O ##1 (CMD_READY_O || USB_REQ_I || TMR_REQ_I);
  endsequence

  ////////////////////////////////////////////////////////////
  a_reset_fetch_zero: assert property ($fell(SYS_RST_I) |-> FETCH_ADDR_O == VEC_RESET)
    else $error("fetch did not start at zero after reset");
  a_usb_vector: assert property (INT_ACK_USB_O |=> FETCH_ADDR_O == VEC_USB)
    else $error("usb interrupt went to the wrong address");
  a_tmr_vector: assert property (INT_ACK_TMR_O |=> FETCH_ADDR_O == VEC_TMR)
    else $error("timer interrupt went to the wrong address");
  a_usb_first: assert property (INT_ACK_TMR_O |-> !USB_REQ_I && !INT_ACK_USB_O)
    else $error("timer taken while usb request waited");
  a_full_no_ack: assert property (STACK_FULL_O |-> !(INT_ACK_USB_O || INT_ACK_TMR_O))
    else $error("interrupt acknowledged with a full stack");
  a_deferred_take: assert property (STACK_FULL_O && USB_REQ_I && ret_take |-> ##[1:3] INT_ACK_USB_O)
    else $error("deferred interrupt not taken after return");
  a_int_stall: assert property (INT_ACK_USB_O || INT_ACK_TMR_O |-> s_int_stall)
    else $error("interrupt entry did not stall exactly two cycles");
  a_table_two: assert property (s_taken(OP_TBL_CUR) or s_taken(OP_TBL_LAST) |=> !CMD_READY_O)
    else $error("table read finished in one cycle");
  a_call_target: assert property (s_taken(OP_CALL) |=> FETCH_ADDR_O == $past(CMD_TARGET_I))
    else $error("call did not land on its target");
  a_bank_one: assert property (EXT_SEL_O && EXT_BANK_O && CMD_READY_O |-> CMD_ADDR_I == ADR_IND1)
    else $error("bank one reached other than through second pointer");
  a_int_return: assert property (s_taken(OP_INT_RET) |-> INT_RETURN_O)
    else $error("interrupt return not flagged");
endmodule : mas_mem_addr_stack_chk

bind mas_mem_addr_stack mas_mem_addr_stack_chk u_chk (.*);

// ---- test/mas_mem_addr_stack_test.sv ----
/*
  Self-checking bench: drives every command and interrupt port directly.
  Assumes the package is compiled first and the checker is bound separately.
*/
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("unexpected %s: expected %h, seen %h", nm, exp, got); end end
module mas_mem_addr_stack_test;
  import mas_pkg::*;
  logic        CLK_I = 1'b0, SYS_RST_I = 1'b1, PM_WE_I = 1'b0, CMD_VALID_I = 1'b0;
  logic        CMD_USE_IMM_I = 1'b0, USB_REQ_I = 1'b0, TMR_REQ_I = 1'b0;
  logic [10:0] PM_WADDR_I = 11'h000, CMD_TARGET_I = 11'h000, FETCH_ADDR_O;
  logic [13:0] PM_WDATA_I = 14'h0000, FETCH_WORD_O;
  logic [7:0]  CMD_IMM_I = 8'h00, EXT_RDATA_I = 8'hc3, EXT_WDATA_O, ACCUM_O;
  logic [6:0]  CMD_ADDR_I = 7'h00, EXT_ADDR_O;
  logic [3:0]  FLAGS_O;
  logic [2:0]  CMD_BIT_I = 3'h0;
  logic        CMD_READY_O, INT_ACK_USB_O, INT_ACK_TMR_O, INT_RETURN_O, EXT_SEL_O;
  logic        EXT_WE_O, EXT_BANK_O, STACK_FULL_O;
  mas_op_t     CMD_OP_I = OP_NOP;
  mas_fn_t     CMD_FN_I = FN_MOVE;
  mas_dst_t    CMD_DST_I = DST_NONE;
  int          error_cnt = 0, samples_checked = 0;
  logic [15:0] ext_last = 16'h0000;

  // Device under test; outside registers answer with a fixed pattern
  mas_mem_addr_stack #(.TABLE_POINTER_HIGH_OPTION(1'b0)) uut (.*);

  always #50 CLK_I = ~CLK_I;

  // Last outside write as {bank, address, data}; the port pulses only one cycle
  always @(posedge CLK_I) if (EXT_WE_O === 1'b1) ext_last <= {EXT_BANK_O, EXT_ADDR_O, EXT_WDATA_O};
  ////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // One command, held until ready was high at a rising edge
  task automatic cmd(mas_op_t op, mas_fn_t fn, mas_dst_t dst, logic [6:0] a, logic ui,
                     logic [10:0] w);
    int n;
    n = 0;
    @(posedge CLK_I);
    #1;
    CMD_OP_I = op;
    CMD_FN_I = fn;
    CMD_DST_I = dst;
    {CMD_ADDR_I, CMD_USE_IMM_I, CMD_IMM_I, CMD_BIT_I, CMD_TARGET_I} = {a, ui, w[7:0], w[2:0], w};
    CMD_VALID_I = 1'b1;
    @(negedge CLK_I);
    while (CMD_READY_O !== 1'b1) begin
      n++;
      if (n > 20) begin
        `CHK("ready", 1'b1, CMD_READY_O)
        test_done();
      end
      @(negedge CLK_I);
    end
    @(posedge CLK_I);
    #1;
    CMD_VALID_I = 1'b0;
  endtask : cmd

  // Data space goes through the accumulator, though a DST_MEM move could write an immediate directly
  task automatic wr(logic [6:0] a, logic [7:0] v);
    cmd(OP_ALU, FN_MOVE, DST_ACCUM, 7'h00, 1'b1, {3'h0, v});
    cmd(OP_ALU, FN_MOVE, DST_PASS, a, 1'b0, 11'h000);
  endtask : wr

  task automatic rd(logic [6:0] a, logic [7:0] v, string nm);
    cmd(OP_ALU, FN_MOVE, DST_ACCUM, a, 1'b0, 11'h000);
    `CHK(nm, v, ACCUM_O)
  endtask : rd

  // Accumulator a, immediate b; zc and m are {zero, carry} value and mask
  task automatic alu(mas_fn_t fn, logic [7:0] a, b, r, logic [1:0] zc, m);
    cmd(OP_ALU, FN_MOVE, DST_ACCUM, 7'h00, 1'b1, {3'h0, a});
    cmd(OP_ALU, fn, DST_ACCUM, 7'h00, 1'b1, {3'h0, b});
    `CHK("alu result", r, ACCUM_O)
    if (m[1]) `CHK("zero flag", zc[1], FLAGS_O[FLG_Z])
    if (m[0]) `CHK("carry flag", zc[0], FLAGS_O[FLG_C])
  endtask : alu

  task automatic pm(logic [10:0] a, logic [13:0] w);
    @(posedge CLK_I);
    #1;
    {PM_WE_I, PM_WADDR_I, PM_WDATA_I} = {1'b1, a, w};
    @(posedge CLK_I);
    #1;
    PM_WE_I = 1'b0;
  endtask : pm

  // Wait for the acknowledge pulse, drop the request, check the vector
  task automatic take_int(logic usb, logic [10:0] vec);
    int n;
    n = 0;
    @(negedge CLK_I);
    while ((usb ? INT_ACK_USB_O : INT_ACK_TMR_O) !== 1'b1) begin
      n++;
      if (n > 20) begin
        `CHK("interrupt ack", 1'b1, 1'b0)
        test_done();
      end
      @(negedge CLK_I);
    end
    @(posedge CLK_I);
    #1;
    {USB_REQ_I, TMR_REQ_I} = 2'b00;
    `CHK("vector", vec, FETCH_ADDR_O)
  endtask : take_int

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge CLK_I);
    #1;
    SYS_RST_I = 1'b0;
    `CHK("pc after reset", 11'h000, FETCH_ADDR_O)
    rd(ADR_BANK, 8'h00, "bank select");
    $display("test reset done");
    wr(7'h20, 8'ha5);
    wr(7'h7f, 8'h3c);
    rd(7'h20, 8'ha5, "ram 20");
    rd(7'h7f, 8'h3c, "ram 7f");
    rd(7'h0c, 8'h00, "hole 0c");
    wr(ADR_TBL_HI, 8'hff);
    rd(ADR_TBL_HI, 8'h00, "table high");
    wr(7'h40, 8'h00);
    cmd(OP_SETB, FN_MOVE, DST_NONE, 7'h40, 1'b0, 11'h007);
    cmd(OP_SETB, FN_MOVE, DST_NONE, 7'h40, 1'b0, 11'h000);
    cmd(OP_CLRB, FN_MOVE, DST_NONE, 7'h40, 1'b0, 11'h007);
    rd(7'h40, 8'h01, "bit ops");
    $display("test data done");
    wr(ADR_MPTR0, 8'h21);
    wr(ADR_IND0, 8'h5a);
    rd(7'h21, 8'h5a, "via pointer 0");
    wr(ADR_MPTR0, 8'h00);
    rd(ADR_IND0, 8'h00, "pointer at port");
    wr(7'h30, 8'h11);
    wr(ADR_MPTR1, 8'h30);
    wr(ADR_BANK, 8'h01);
    rd(ADR_IND1, 8'hc3, "bank 1 via pointer 1");
    wr(ADR_IND1, 8'h77);
    `CHK("outside write", 16'hb077, ext_last)
    rd(ADR_BANK, 8'h01, "bank in bank 1");
    wr(ADR_MPTR0, 8'h30);
    rd(ADR_IND0, 8'h11, "pointer 0 bank 0");
    wr(ADR_BANK, 8'h00);
    rd(ADR_IND1, 8'h11, "bank 0 via pointer 1");
    $display("test indirect done");
    alu(FN_ADD, 8'hff, 8'h01, 8'h00, 2'b11, 2'b11);
    alu(FN_ADC, 8'h10, 8'h01, 8'h12, 2'b00, 2'b11);
    alu(FN_SUB, 8'h05, 8'h05, 8'h00, 2'b11, 2'b11);
    alu(FN_SBC, 8'h05, 8'h01, 8'h04, 2'b01, 2'b11);
    alu(FN_SUB, 8'h03, 8'h05, 8'hfe, 2'b00, 2'b11);
    alu(FN_RRC, 8'h01, 8'h01, 8'h00, 2'b01, 2'b01);
    alu(FN_RLC, 8'h80, 8'h80, 8'h01, 2'b01, 2'b01);
    alu(FN_AND, 8'hf0, 8'h0f, 8'h00, 2'b10, 2'b10);
    alu(FN_OR,  8'hf0, 8'h0f, 8'hff, 2'b00, 2'b10);
    alu(FN_XOR, 8'hff, 8'h0f, 8'hf0, 2'b00, 2'b10);
    alu(FN_CPL, 8'h0f, 8'h0f, 8'hf0, 2'b00, 2'b10);
    alu(FN_RL,  8'h81, 8'h81, 8'h03, 2'b00, 2'b00);
    alu(FN_RR,  8'h81, 8'h81, 8'hc0, 2'b00, 2'b00);
    alu(FN_INC, 8'hff, 8'hff, 8'h00, 2'b10, 2'b10);
    alu(FN_DEC, 8'h00, 8'h00, 8'hff, 2'b00, 2'b10);
    alu(FN_ADD, 8'h01, 8'h01, 8'h02, 2'b00, 2'b11);
    alu(FN_DAA, 8'h0a, 8'h0a, 8'h10, 2'b00, 2'b01);
    $display("test alu done");
    pm(11'h3f0, 14'h3abc);
    pm(11'h3ab, 14'h15c3);
    pm(11'h7ab, 14'h2a5c);
    cmd(OP_JMP, FN_MOVE, DST_NONE, 7'h00, 1'b0, 11'h3f0);
    `CHK("fetch word", 14'h3abc, FETCH_WORD_O)
    wr(ADR_TPTR_LO, 8'hab);
    cmd(OP_TBL_CUR, FN_MOVE, DST_NONE, 7'h50, 1'b0, 11'h000);
    rd(7'h50, 8'hc3, "current page low");
    rd(ADR_TBL_HI, 8'h15, "current page high");
    cmd(OP_TBL_LAST, FN_MOVE, DST_NONE, 7'h50, 1'b0, 11'h000);
    rd(7'h50, 8'h5c, "last page low");
    rd(ADR_TBL_HI, 8'h2a, "last page high");
    wr(ADR_PC_LOW, 8'h10);
    `CHK("short jump", 11'h310, FETCH_ADDR_O)
    $display("test table done");
    cmd(OP_JMP, FN_MOVE, DST_NONE, 7'h00, 1'b0, 11'h100);
    for (int i = 0; i < 5; i++) cmd(OP_CALL, FN_MOVE, DST_NONE, 7'h00, 1'b0, 11'h200 + 11'(i * 256));
    `CHK("stack full", 1'b1, STACK_FULL_O)
    for (int i = 0; i < 4; i++) begin
      cmd(OP_SUB_RET, FN_MOVE, DST_NONE, 7'h00, 1'b0, 11'h000);
      `CHK("return pc", 11'h501 - 11'(i * 256), FETCH_ADDR_O)
    end
    `CHK("stack empty", 1'b0, STACK_FULL_O)
    cmd(OP_JMP, FN_MOVE, DST_NONE, 7'h00, 1'b0, 11'h080);
    cmd(OP_SKZ, FN_MOVE, DST_NONE, 7'h00, 1'b1, 11'h000);
    cmd(OP_SKNZ, FN_MOVE, DST_NONE, 7'h00, 1'b1, 11'h000);
    cmd(OP_NOP, FN_MOVE, DST_NONE, 7'h00, 1'b0, 11'h000);
    `CHK("skip pc", 11'h084, FETCH_ADDR_O)
    $display("test stack done");
    for (int i = 0; i < 4; i++) cmd(OP_CALL, FN_MOVE, DST_NONE, 7'h00, 1'b0, 11'h200);
    USB_REQ_I = 1'b1;
    repeat (5) @(posedge CLK_I);
    #1;
    `CHK("deferred while full", 11'h200, FETCH_ADDR_O)
    cmd(OP_SUB_RET, FN_MOVE, DST_NONE, 7'h00, 1'b0, 11'h000);
    take_int(1'b1, VEC_USB);
    cmd(OP_INT_RET, FN_MOVE, DST_NONE, 7'h00, 1'b0, 11'h000);
    TMR_REQ_I = 1'b1;
    take_int(1'b0, VEC_TMR);
    cmd(OP_INT_RET, FN_MOVE, DST_NONE, 7'h00, 1'b0, 11'h000);
    `CHK("timer return", 11'h201, FETCH_ADDR_O)
    $display("test interrupt done");
    test_done();
  end
endmodule : mas_mem_addr_stack_test
